/* File: design/pulse_accumulator.sv */
/*
  Pulse accumulator: 8-bit event counter or gated time accumulator,
  control, count, mask and flag registers on APB, one interrupt request.
  Assumes the pulse pin is asynchronous and stays below half the clock rate.
*/
`timescale 1ns/1ps
module pulse_accumulator
  import pacc_pkg::*;
#(
  parameter int GATE_DIV = PACC_GATE_DIV
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sharedPulsePin,
  output logic             accumIrq
);
  //****************************************************************
  // input conditioning
  //****************************************************************
  logic pulseInput;
  logic pulsePrev_ff;
  logic nxt_pulsePrev;
  logic gateTick;

  initial
  begin
    if (GATE_DIV < 2)
      $error("pulse_accumulator: GATE_DIV must be at least 2");
  end

  // pin level is sampled regardless of port direction
  pacc_sync u_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (sharedPulsePin),
    .syncOut (pulseInput)
  );

  pacc_divider #(.DIV(GATE_DIV)) u_div (
    .clk  (clk),
    .rst  (rst),
    .tick (gateTick)
  );

  //****************************************************************
  // register decode
  //****************************************************************
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  logic wrAcc;
  logic rdAcc;
  logic wrByte0;
  logic mapped;

  assign wrAcc   = psel & penable & pwrite;
  assign rdAcc   = psel & penable & ~pwrite;
  assign wrByte0 = wrAcc & pstrb[0];
  assign mapped  = hit(paddr, PACC_OFS_CONTROL) | hit(paddr, PACC_OFS_COUNT) |
                   hit(paddr, PACC_OFS_MASK) | hit(paddr, PACC_OFS_FLAG);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  //****************************************************************
  // control and mask registers
  //****************************************************************
  logic [7:0] control_ff;
  logic [7:0] mask_ff;
  logic [7:0] nxt_control;
  logic [7:0] nxt_mask;
  logic       accumEnable;
  logic       accumModeSelect;
  logic       edgeSelect;

  always_comb
  begin
    nxt_control = control_ff;
    nxt_mask    = mask_ff;
    if (wrByte0 && hit(paddr, PACC_OFS_CONTROL))
      nxt_control = pwdata[7:0] & PACC_CONTROL_WMASK;
    if (wrByte0 && hit(paddr, PACC_OFS_MASK))
      nxt_mask = pwdata[7:0] & PACC_FLAG_WMASK;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      control_ff <= PACC_CONTROL_RST;
      mask_ff    <= PACC_CONTROL_RST;
    end
    else
    begin
      control_ff <= nxt_control;
      mask_ff    <= nxt_mask;
    end
  end

  assign accumEnable     = control_ff[PACC_BIT_ENABLE];
  assign accumModeSelect = control_ff[PACC_BIT_MODE];
  assign edgeSelect      = control_ff[PACC_BIT_EDGE];

  //****************************************************************
  // edge detect and count qualification
  //****************************************************************
  logic riseSeen;
  logic fallSeen;
  logic selEdge;
  logic gateOpen;
  logic countStep;

  assign nxt_pulsePrev = pulseInput;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pulsePrev_ff <= 1'b0;
    else
      pulsePrev_ff <= nxt_pulsePrev;
  end

  assign riseSeen = pulseInput & ~pulsePrev_ff;
  assign fallSeen = ~pulseInput & pulsePrev_ff;
  // edge flag follows the edge bit in both modes
  assign selEdge  = edgeSelect ? riseSeen : fallSeen;
  assign gateOpen = edgeSelect ? ~pulseInput : pulseInput;
  always_comb
  begin
    countStep = 1'b0;
    if (accumEnable)
    begin
      if (!accumModeSelect)
        countStep = selEdge;
      else
        countStep = gateTick & gateOpen;
    end
  end

  //****************************************************************
  // count register
  //****************************************************************
  // no reset: count survives reset untouched
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic       wrapEvent;

  always_comb
  begin
    nxt_count = count_ff;
    wrapEvent = 1'b0;
    if (wrByte0 && hit(paddr, PACC_OFS_COUNT))
      nxt_count = pwdata[7:0];
    else if (countStep)
    begin
      nxt_count = 8'(count_ff + 8'h01);
      wrapEvent = (count_ff == 8'hFF);
    end
  end

  // read data is registered, so a read sees the value before this edge's increment
  always_ff @(posedge clk)
  begin
    count_ff <= nxt_count;
  end

  //****************************************************************
  // flags
  //****************************************************************
  logic ovfFlag_ff;
  logic edgeFlag_ff;
  logic nxt_ovfFlag;
  logic nxt_edgeFlag;
  logic flagWr;

  assign flagWr = wrByte0 & hit(paddr, PACC_OFS_FLAG);

  always_comb
  begin
    nxt_ovfFlag  = ovfFlag_ff;
    nxt_edgeFlag = edgeFlag_ff;
    if (flagWr && pwdata[PACC_BIT_OVF])
      nxt_ovfFlag = 1'b0;
    if (flagWr && pwdata[PACC_BIT_EDGEF])
      nxt_edgeFlag = 1'b0;
    if (wrapEvent)
      nxt_ovfFlag = 1'b1;
    if (accumEnable && selEdge)
      nxt_edgeFlag = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ovfFlag_ff  <= 1'b0;
      edgeFlag_ff <= 1'b0;
    end
    else
    begin
      ovfFlag_ff  <= nxt_ovfFlag;
      edgeFlag_ff <= nxt_edgeFlag;
    end
  end

  // level request; handler clears the flag to drop it
  assign accumIrq = (ovfFlag_ff & mask_ff[PACC_BIT_OVF]) |
                    (edgeFlag_ff & mask_ff[PACC_BIT_EDGEF]);

  //****************************************************************
  // read data
  //****************************************************************
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [7:0]  flagView;

  assign flagView = {2'b00, ovfFlag_ff, edgeFlag_ff, 4'h0};

  always_comb
  begin
    nxt_rdata = 32'h00000000;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        PACC_OFS_CONTROL: nxt_rdata = {24'h000000, control_ff};
        PACC_OFS_COUNT:   nxt_rdata = {24'h000000, count_ff};
        PACC_OFS_MASK:    nxt_rdata = {24'h000000, mask_ff};
        PACC_OFS_FLAG:    nxt_rdata = {24'h000000, flagView};
        default:          nxt_rdata = 32'h00000000;
      endcase
    end
    else if (rdAcc)
      nxt_rdata = rdata_ff;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_ff <= 32'h00000000;
    else
      rdata_ff <= nxt_rdata;
  end

  assign prdata = rdata_ff;
endmodule

/* File: design/pacc_pkg.sv */
/*
  Constants for the pulse accumulator: APB register map, field
  positions, reset values and the gated-mode tick divider.
  Assumes a single 125 MHz bus clock and APB with 32-bit data.
*/
// Functional notes
// - event mode adds one to the 8-bit count per qualifying input edge.
// - gated mode counts a free-running clock/64 tick while input is active.
// - software reads or writes the count at any time.
// - pin level feeds the accumulator even when driven as an output.
// - enable bit 0 stops the accumulator, 1 runs it.
// - event mode: edge bit 0 counts falling, 1 counts rising edges.
// - gated mode: edge bit 0 low inhibits, 1 high inhibits.
// - reset leaves the count untouched; it has no reset value.
// - increments and software reads fall in opposite half cycles; here both occur on the rising clock edge, the read being registered.
// - overflow flag sets when the count wraps from FF to 00.
// - writing one to flag bit 5 clears overflow; zero leaves it.
// - overflow enable raises a request on flag set, never alters flag.
// - edge flag sets on each selected edge at the pulse pin while enable bit is 1.
// - writing one to flag bit 4 clears the edge flag; zero leaves it.
// - edge enable only gates the request, never the edge flag.
package pacc_pkg;
  localparam logic [11:0] PACC_OFS_CONTROL = 12'h000;
  localparam logic [11:0] PACC_OFS_COUNT   = 12'h004;
  localparam logic [11:0] PACC_OFS_MASK    = 12'h008;
  localparam logic [11:0] PACC_OFS_FLAG    = 12'h00C;

  localparam int PACC_BIT_ENABLE = 6;
  localparam int PACC_BIT_MODE   = 5;
  localparam int PACC_BIT_EDGE   = 4;
  localparam int PACC_BIT_OVF    = 5;
  localparam int PACC_BIT_EDGEF  = 4;

  localparam logic [7:0] PACC_CONTROL_RST = 8'h00;
  localparam logic [7:0] PACC_CONTROL_WMASK = 8'h70;
  localparam logic [7:0] PACC_FLAG_WMASK  = 8'h30;

  localparam int PACC_GATE_DIV = 64;
  localparam int PACC_SYNC_STAGES = 2;
endpackage

/* File: design/pacc_sync.sv */
/*
  Two-stage synchroniser for the pulse pin level.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module pacc_sync
  import pacc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic stage1_ff;
  logic stage2_ff;
  logic nxt_stage1;
  logic nxt_stage2;

  always_comb
  begin
    nxt_stage1 = asyncIn;
    nxt_stage2 = stage1_ff;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end
    else
    begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign syncOut = stage2_ff;
endmodule

/* File: design/pacc_divider.sv */
/*
  Free-running divider giving a one-cycle tick every DIV clocks.
  Assumes it runs from reset on and is never stopped by software.
*/
`timescale 1ns/1ps
module pacc_divider
  import pacc_pkg::*;
#(
  parameter int DIV = PACC_GATE_DIV
)
(
  input  wire logic clk,
  input  wire logic rst,
  output logic      tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  initial
  begin
    if (DIV < 2)
      $error("pacc_divider: DIV must be at least 2");
  end

  always_comb
  begin
    nxt_cnt = (cnt_ff == LAST) ? '0 : W'(cnt_ff + 1'b1);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

  assign tick = (cnt_ff == LAST);
endmodule

/* File: testbench/pacc_pin_source.sv */
/* Pulse pin source model: drives the shared pulse pin toward a level.
   Assumes the bench changes the level request just after a clock edge. */
`timescale 1ns/1ps
module pacc_pin_source
#(
  parameter int HOLD = 3
)
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic level,
  output logic      pin
);
  logic [3:0] holdFf;
  logic [3:0] nxt_hold;
  logic       pinFf;
  logic       nxt_pin;
  assign pin = pinFf;
  always_comb
  begin
    nxt_pin  = pinFf;
    nxt_hold = (holdFf != 4'h0) ? holdFf - 4'h1 : 4'h0;
    if (holdFf == 4'h0 && level != pinFf)
    begin
      nxt_pin  = level;
      nxt_hold = 4'(HOLD);
    end
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pinFf  <= 1'h0;
      holdFf <= 4'h0;
    end
    else
    begin
      pinFf  <= nxt_pin;
      holdFf <= nxt_hold;
    end
  end
endmodule

/* File: testbench/pacc_assertions.sv */
/* Port checker for the pulse accumulator, bound to the top module.
   Assumes an APB master that keeps setup then access order. */
`timescale 1ns/1ps
module pacc_assertions
  import pacc_pkg::*;
#(
  parameter int GATE_DIV = PACC_GATE_DIV
)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sharedPulsePin,
  input wire logic        accumIrq
);
  logic       wrAcc;
  logic       rdAcc;
  logic       badAdr;
  logic [7:0] ctlFf;
  logic [7:0] nxt_ctl;
  logic [7:0] mskFf;
  logic [7:0] nxt_msk;
  assign wrAcc  = psel && penable && pwrite && pstrb[0];
  assign rdAcc  = psel && penable && !pwrite;
  assign badAdr = paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0;
  always_comb
  begin
    nxt_ctl = ctlFf;
    nxt_msk = mskFf;
    if (wrAcc && paddr == PACC_OFS_CONTROL)
      nxt_ctl = pwdata[7:0] & PACC_CONTROL_WMASK;
    if (wrAcc && paddr == PACC_OFS_MASK)
      nxt_msk = pwdata[7:0] & PACC_FLAG_WMASK;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctlFf <= 8'h00;
      mskFf <= 8'h00;
    end
    else
    begin
      ctlFf <= nxt_ctl;
      mskFf <= nxt_msk;
    end
  end
  // ****
  // checks
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ready_tied_a: assert property (psel |-> pready) else $error("pready low");
  err_unmapped_a: assert property (psel && penable |-> pslverr == badAdr) else $error("pslverr wrong");
  err_idle_a: assert property (!penable |-> !pslverr) else $error("pslverr outside access");
  rd_unmapped_a: assert property (rdAcc && badAdr |-> prdata == 32'h0) else $error("unmapped read");
  rd_upper_a: assert property (rdAcc |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  ctl_readback_a: assert property (rdAcc && paddr == PACC_OFS_CONTROL |-> prdata[7:0] == ctlFf)
    else $error("control readback");
  irq_masked_a: assert property (mskFf == 8'h00 |-> !accumIrq)
    else $error("irq with enables off");
  idle_no_irq_a: assert property (!ctlFf[6] && $past(!ctlFf[6]) && $stable(mskFf) |-> !$rose(accumIrq))
    else $error("irq while disabled");
  flag_clear_a: assert property (wrAcc && paddr == PACC_OFS_FLAG && pwdata[5:4] == 2'h3 && !ctlFf[6]
    |=> !accumIrq) else $error("flags not cleared");
endmodule
bind pulse_accumulator pacc_assertions #(.GATE_DIV(GATE_DIV)) chk_u (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sharedPulsePin, .accumIrq);

/* File: testbench/pulse_accumulator_test.sv */
/* Directed bench for the pulse accumulator over APB with a pin source.
   Assumes the pin source model and the bound checker are compiled. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin errTotal++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module pulse_accumulator_test
  import pacc_pkg::*;
;
  localparam logic [11:0] CTL = PACC_OFS_CONTROL;
  localparam logic [11:0] CNT = PACC_OFS_COUNT;
  localparam logic [11:0] MSK = PACC_OFS_MASK;
  localparam logic [11:0] FLG = PACC_OFS_FLAG;
  logic        clk       = 1'h0;
  logic        rst       = 1'h1;
  logic        psel      = 1'h0;
  logic        penable   = 1'h0;
  logic        pwrite    = 1'h0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic [3:0]  pstrb     = 4'hF;
  logic        lvl       = 1'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin;
  logic        accumIrq;
  logic [7:0]  rd;
  int          errTotal  = 0;
  int          numChecks = 0;
  pulse_accumulator #(.GATE_DIV(4)) dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .sharedPulsePin(pin), .accumIrq);
  pacc_pin_source #(.HOLD(3)) src_u (.clk, .rst, .level(lvl), .pin);
  initial
  begin
    forever #4 clk = ~clk;
  end
  task automatic stopTest();
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata[7:0];
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e, input string n);
    apb(1'h0, a, 8'h00);
    `CHK(n, e, rd)
  endtask
  task automatic ci(input logic e, input string n);
    wt(1);
    `CHK(n, e, accumIrq)
  endtask
  task automatic lv(input logic v);
    lvl <= v;
    wt(12);
  endtask
  // ****
  // tests
  // ****
  initial
  begin
    wt(6);
    rst <= 1'h0;
    rc(CTL, 8'h00, "ctl rst");
    rc(MSK, 8'h00, "msk rst");
    rc(FLG, 8'h00, "flg rst");
    apb(1'h1, 12'h010, 8'hFF);
    rc(12'h010, 8'h00, "unmapped");
    apb(1'h1, CNT, 8'h5A);
    rc(CNT, 8'h5A, "cnt wr");
    rst <= 1'h1;
    wt(6);
    rst <= 1'h0;
    rc(CNT, 8'h5A, "cnt kept");
    apb(1'h1, CTL, 8'hFF);
    rc(CTL, 8'h70, "ctl wr");
    apb(1'h1, CTL, 8'h50);
    apb(1'h1, CNT, 8'hFD);
    repeat (3)
    begin
      lv(1'h1);
      lv(1'h0);
    end
    rc(CNT, 8'h00, "cnt wrap");
    rc(FLG, 8'h30, "flg set");
    ci(1'h0, "irq masked");
    apb(1'h1, MSK, 8'h30);
    ci(1'h1, "irq on");
    apb(1'h1, FLG, 8'h00);
    rc(FLG, 8'h30, "flg kept");
    apb(1'h1, FLG, 8'h10);
    rc(FLG, 8'h20, "flg ovf");
    ci(1'h1, "irq ovf");
    apb(1'h1, FLG, 8'h20);
    rc(FLG, 8'h00, "flg clr");
    ci(1'h0, "irq clr");
    apb(1'h1, CTL, 8'h40);
    apb(1'h1, CNT, 8'h10);
    lv(1'h1);
    rc(CNT, 8'h10, "fall hi");
    lv(1'h0);
    rc(CNT, 8'h11, "fall lo");
    apb(1'h1, CTL, 8'h00);
    apb(1'h1, FLG, 8'h30);
    lv(1'h1);
    lv(1'h0);
    rc(CNT, 8'h11, "off cnt");
    rc(FLG, 8'h00, "off flg");
    apb(1'h1, CTL, 8'h60);
    apb(1'h1, CNT, 8'h00);
    wt(40);
    rc(CNT, 8'h00, "gate lo");
    lv(1'h1);
    apb(1'h1, CNT, 8'h00);
    wt(40);
    apb(1'h0, CNT, 8'h00);
    `CHK("gate ticks", 1'h1, rd >= 8'h0A && rd <= 8'h0B)
    rc(FLG, 8'h00, "gate flg");
    apb(1'h1, CTL, 8'h70);
    apb(1'h1, CNT, 8'h00);
    wt(40);
    rc(CNT, 8'h00, "gate inh");
    stopTest();
  end
  initial
  begin
    wt(5000);
    errTotal++;
    stopTest();
  end
endmodule
